// ==== design/sstc_bus_mon.sv ====
// Start and stop detection and bus busy tracking on the two bus lines
module sstc_bus_mon (
  input wire logic clk_i,       // System clock
  input wire logic sys_rst_i,   // Async reset, active high
  input wire logic scl_i,       // Clock line level
  input wire logic sda_i,       // Data line level
  output logic start_det_o,     // One-cycle pulse on start condition
  output logic stop_det_o,      // One-cycle pulse on stop condition
  output logic busy_o           // Bus held between start and stop
);
  logic scl_ff, sda_ff, start_ff, stop_ff, busy_ff;
  logic nxt_start, nxt_stop, nxt_busy;

  always_comb begin
    nxt_start = scl_ff & scl_i & sda_ff & ~sda_i;
    nxt_stop = scl_ff & scl_i & ~sda_ff & sda_i;
    nxt_busy = busy_ff;
    if (nxt_start) begin
      nxt_busy = 1'b1;
    end else if (nxt_stop) begin
      nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
      start_ff <= nxt_start;
      stop_ff <= nxt_stop;
      busy_ff <= nxt_busy;
    end
  end

  assign start_det_o = start_ff;
  assign stop_det_o = stop_ff;
  assign busy_o = busy_ff;
endmodule : sstc_bus_mon

// ==== design/sstc_cond_gen.sv ====
// Drives start, repeated start and stop conditions onto the bus lines
module sstc_cond_gen #(
  parameter int SU_CYC = sstc_pkg::START_SU_CYC,
  parameter int HD_CYC = sstc_pkg::START_HD_CYC
) (
  input wire logic clk_i,        // System clock
  input wire logic sys_rst_i,    // Async reset, active high
  input wire logic start_i,      // Pulse: produce a start condition
  input wire logic stop_i,       // Pulse: produce a stop condition
  input wire logic stop_fast_i,  // Stop while clock line already high
  output logic scl_oe_o,         // Pull clock line low
  output logic sda_oe_o,         // Pull data line low
  output logic busy_o,           // Sequence in progress
  output logic start_done_o      // Pulse: start condition completed
);
  sstc_pkg::sstc_gen_state_type state_ff, nxt_state;
  logic [sstc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic cnt_end;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_done = 1'b0;
    cnt_end = 1'b0;
    case (state_ff)
      sstc_pkg::GEN_IDLE: begin
        nxt_cnt = '0;
        if (start_i) begin
          nxt_state = sstc_pkg::GEN_ST_SU;
        end else if (stop_i & stop_fast_i) begin
          nxt_state = sstc_pkg::GEN_SP_SU;
        end else if (stop_i) begin
          nxt_state = sstc_pkg::GEN_SP_LOW;
        end
      end
      sstc_pkg::GEN_ST_SU, sstc_pkg::GEN_SP_LOW, sstc_pkg::GEN_SP_SU: begin
        cnt_end = cnt_ff == sstc_pkg::CNT_W'(SU_CYC - 1);
      end
      default: begin
        cnt_end = cnt_ff == sstc_pkg::CNT_W'(HD_CYC - 1);
      end
    endcase
    if (cnt_end) begin
      nxt_cnt = '0;
      case (state_ff)
        sstc_pkg::GEN_ST_SU: nxt_state = sstc_pkg::GEN_ST_HD;
        sstc_pkg::GEN_ST_HD: nxt_state = sstc_pkg::GEN_ST_LOW;
        sstc_pkg::GEN_SP_LOW: nxt_state = sstc_pkg::GEN_SP_SU;
        default: nxt_state = sstc_pkg::GEN_IDLE;
      endcase
      nxt_done = state_ff == sstc_pkg::GEN_ST_LOW;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= sstc_pkg::GEN_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  // Start: data falls while clock high, then clock pulled low
  assign scl_oe_o = (state_ff == sstc_pkg::GEN_ST_LOW) | (state_ff == sstc_pkg::GEN_SP_LOW);
  assign sda_oe_o = (state_ff != sstc_pkg::GEN_IDLE) & (state_ff != sstc_pkg::GEN_ST_SU);
  assign busy_o = state_ff != sstc_pkg::GEN_IDLE;
  assign start_done_o = done_ff;
endmodule : sstc_cond_gen

// ==== design/sstc_trigger_ctrl.sv ====
// Start/stop trigger control of the two-wire bus controller, Avalon-MM slave
//
// Added by the designer: the address map and the Avalon-MM slave port.
module sstc_trigger_ctrl (
  input wire logic clk_i,                 // System clock, 100 MHz
  input wire logic sys_rst_i,             // Async reset, active high
  input wire logic [4:0] avs_address_i,   // Register byte address
  input wire logic avs_read_i,            // Read request
  input wire logic avs_write_i,           // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o,     // Read data
  output logic avs_waitrequest_o,         // Stall request
  input wire logic scl_i,                 // Clock line level
  output logic scl_o,                     // Clock line drive value
  output logic scl_oe_o,                  // Clock line pulled low
  input wire logic sda_i,                 // Data line level
  output logic sda_o,                     // Data line drive value
  output logic sda_oe_o,                  // Data line pulled low
  input wire logic eng_scl_oe_i,          // Engine holds clock low
  input wire logic eng_sda_oe_i,          // Engine pulls data low
  input wire logic mst_wait_i,            // Master wait state level
  input wire logic wait8_i,               // Wait after eight clocks
  input wire logic ninth_clk_i,           // Ninth clock period
  input wire logic ninth_high_i,          // High phase of ninth clock
  input wire logic tx_set_i,              // Engine entered transmit state
  input wire logic shift_wr_i,            // Shift register written
  input wire logic arb_lost_i,            // Arbitration lost pulse
  output logic unit_enable_o,             // Unit enable level
  output logic ack_enable_o,              // Acknowledge enable level
  output logic wait_timing_o,             // Wait timing select level
  output logic wait_end_o,                // Pulse: end current wait
  output logic irq_o                      // Level interrupt
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ue_ff, acke_ff, wtim_ff, stt_ff, spt_ff, rsvd_ff, stcf_ff;
  logic msts_ff, ald_ff, trc_ff, sda_rel_ff, rs_ok_ff, wend_ff;
  logic go_st_ff, go_sp_ff, fast_ff, sp_sent_ff, ack_ff;
  logic [sstc_pkg::IRQ_W-1:0] irq_st_ff, irq_mask_ff;
  logic [31:0] rdata_ff;
  logic nxt_ue, nxt_acke, nxt_wtim, nxt_stt, nxt_spt, nxt_rsvd, nxt_stcf;
  logic nxt_msts, nxt_ald, nxt_trc, nxt_sda_rel, nxt_rs_ok, nxt_wend;
  logic nxt_go_st, nxt_go_sp, nxt_fast, nxt_sp_sent, nxt_ack;
  logic [sstc_pkg::IRQ_W-1:0] nxt_irq_st, nxt_irq_mask, irq_ev;
  logic [31:0] nxt_rdata;
  logic req, wr_en, rd_en, wr_c0, exit_p, off_p, stcf_ev, gen_idle, in_fast;
  logic [7:0] wd;
  logic gen_scl_oe, gen_sda_oe, gen_busy, st_done;
  logic start_det, stop_det, bus_busy;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = addr == ofs;
  endfunction : hit

  function automatic logic [31:0] rd_mux(input logic [4:0] addr);
    logic [31:0] v;
    v = '0;
    if (hit(addr, sstc_pkg::ADDR_CTRL0)) begin
      v[sstc_pkg::C0_UNIT_ENABLE] = ue_ff;
      v[sstc_pkg::C0_ACK_ENABLE] = acke_ff;
      v[sstc_pkg::C0_WAIT_TIMING] = wtim_ff;
    end else if (hit(addr, sstc_pkg::ADDR_FLAG)) begin
      v[sstc_pkg::FL_START_CLEAR] = stcf_ff;
      v[sstc_pkg::FL_BUS_BUSY] = bus_busy;
      v[sstc_pkg::FL_RSV_DISABLE] = rsvd_ff;
    end else if (hit(addr, sstc_pkg::ADDR_STAT)) begin
      v[sstc_pkg::ST_MASTER] = msts_ff;
      v[sstc_pkg::ST_ARB_LOST] = ald_ff;
      v[sstc_pkg::ST_TRANSMIT] = trc_ff;
    end else if (hit(addr, sstc_pkg::ADDR_IRQ_STAT)) begin
      v[sstc_pkg::IRQ_W-1:0] = irq_st_ff;
    end else if (hit(addr, sstc_pkg::ADDR_IRQ_MASK)) begin
      v[sstc_pkg::IRQ_W-1:0] = irq_mask_ff;
    end
    rd_mux = v;
  endfunction : rd_mux

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  sstc_cond_gen i_sstc_cond_gen (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(go_st_ff),
    .stop_i(go_sp_ff),
    .stop_fast_i(fast_ff),
    .scl_oe_o(gen_scl_oe),
    .sda_oe_o(gen_sda_oe),
    .busy_o(gen_busy),
    .start_done_o(st_done)
  );

  sstc_bus_mon i_sstc_bus_mon (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .start_det_o(start_det),
    .stop_det_o(stop_det),
    .busy_o(bus_busy)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    req = avs_read_i | avs_write_i;
    nxt_ack = req & ~ack_ff;
    wr_en = avs_write_i & ack_ff;
    rd_en = avs_read_i & ack_ff;
    nxt_rdata = req ? rd_mux(avs_address_i) : rdata_ff;
    wd = avs_writedata_i[7:0];
    wr_c0 = wr_en & avs_byteenable_i[0] & hit(avs_address_i, sstc_pkg::ADDR_CTRL0);
    exit_p = wr_c0 & wd[sstc_pkg::C0_EXIT_COMM];
    nxt_ue = ue_ff;
    nxt_acke = acke_ff;
    nxt_wtim = wtim_ff;
    nxt_stt = stt_ff;
    nxt_spt = spt_ff;
    nxt_rsvd = rsvd_ff;
    nxt_stcf = stcf_ff;
    nxt_msts = msts_ff;
    nxt_ald = ald_ff;
    nxt_trc = trc_ff;
    nxt_sda_rel = sda_rel_ff;
    nxt_rs_ok = rs_ok_ff;
    nxt_wend = 1'b0;
    nxt_sp_sent = sp_sent_ff;
    nxt_irq_mask = irq_mask_ff;
    stcf_ev = 1'b0;
    if (wr_c0) begin
      nxt_ue = wd[sstc_pkg::C0_UNIT_ENABLE];
      nxt_acke = wd[sstc_pkg::C0_ACK_ENABLE];
      nxt_wtim = wd[sstc_pkg::C0_WAIT_TIMING];
    end
    if (wr_c0 & wd[sstc_pkg::C0_START_TRIG] & ue_ff) begin
      if (bus_busy & ~msts_ff & rsvd_ff) begin
        stcf_ev = 1'b1;
      end else begin
        nxt_stt = 1'b1;
      end
    end
    if (wr_c0 & wd[sstc_pkg::C0_STOP_TRIG] & ue_ff & msts_ff) begin
      nxt_spt = 1'b1;
    end
    if (wr_c0 & wd[sstc_pkg::C0_WAIT_RELEASE] & mst_wait_i) begin
      nxt_wend = 1'b1;
      if (trc_ff & ninth_clk_i) begin
        nxt_trc = 1'b0;
        nxt_sda_rel = 1'b1;
      end
    end
    if (shift_wr_i & mst_wait_i) begin
      nxt_wend = 1'b1;
    end
    if (wend_ff & msts_ff) begin
      nxt_rs_ok = 1'b1;
    end
    if (wr_en & avs_byteenable_i[0] & hit(avs_address_i, sstc_pkg::ADDR_FLAG)) begin
      nxt_rsvd = wd[sstc_pkg::FL_RSV_DISABLE];
      nxt_stcf = stcf_ff & ~wd[sstc_pkg::FL_START_CLEAR];
    end
    if (stcf_ev) begin
      nxt_stcf = 1'b1;
    end
    if (wr_en & avs_byteenable_i[0] & hit(avs_address_i, sstc_pkg::ADDR_IRQ_MASK)) begin
      nxt_irq_mask = wd[sstc_pkg::IRQ_W-1:0];
    end
    if (tx_set_i) begin
      nxt_trc = 1'b1;
    end
    if (start_det | stop_det) begin
      nxt_sda_rel = 1'b0;
    end
    if (rd_en & hit(avs_address_i, sstc_pkg::ADDR_STAT)) begin
      nxt_ald = 1'b0;
    end
    if (arb_lost_i) begin
      nxt_ald = 1'b1;
    end
    // Launch a start when the generator is free
    gen_idle = ~gen_busy & ~go_st_ff & ~go_sp_ff & ~st_done;
    nxt_go_st = stt_ff & ue_ff & gen_idle & (~bus_busy | rs_ok_ff);
    // early wait timing stops in ninth high
    in_fast = wait8_i & ~wtim_ff & ninth_high_i;
    nxt_go_sp = spt_ff & ~sp_sent_ff & gen_idle & ~nxt_go_st
      & ((mst_wait_i & ~wait8_i) | in_fast);
    nxt_fast = in_fast;
    if (nxt_go_sp) begin
      nxt_sp_sent = 1'b1;
    end
    if (nxt_go_st) begin
      nxt_rs_ok = 1'b0;
    end
    if (st_done) begin
      nxt_stt = 1'b0;
      nxt_msts = 1'b1;
    end
    if (stop_det) begin
      nxt_msts = 1'b0;
      nxt_spt = 1'b0;
      nxt_sp_sent = 1'b0;
    end
    off_p = ~ue_ff | (wr_c0 & ~wd[sstc_pkg::C0_UNIT_ENABLE]);
    if (arb_lost_i | exit_p | off_p) begin
      nxt_stt = 1'b0;
      nxt_spt = 1'b0;
      nxt_sp_sent = 1'b0;
      nxt_msts = 1'b0;
      nxt_rs_ok = 1'b0;
      nxt_go_st = 1'b0;
      nxt_go_sp = 1'b0;
    end
    if (exit_p | off_p) begin
      nxt_trc = 1'b0;
    end
    if (off_p) begin
      nxt_ald = 1'b0;
    end
    irq_ev = '0;
    irq_ev[sstc_pkg::IRQ_START_DONE] = st_done;
    irq_ev[sstc_pkg::IRQ_STOP_SEEN] = stop_det;
    irq_ev[sstc_pkg::IRQ_ARB_LOST] = arb_lost_i;
    irq_ev[sstc_pkg::IRQ_START_CLR] = stcf_ev;
    nxt_irq_st = irq_st_ff;
    if (wr_en & avs_byteenable_i[0] & hit(avs_address_i, sstc_pkg::ADDR_IRQ_STAT)) begin
      nxt_irq_st = irq_st_ff & ~wd[sstc_pkg::IRQ_W-1:0];
    end
    nxt_irq_st = nxt_irq_st | irq_ev;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ue_ff <= 1'b0;
      acke_ff <= 1'b0;
      wtim_ff <= 1'b0;
      stt_ff <= 1'b0;
      spt_ff <= 1'b0;
      rsvd_ff <= 1'b0;
      stcf_ff <= 1'b0;
      msts_ff <= 1'b0;
      ald_ff <= 1'b0;
      trc_ff <= 1'b0;
      sda_rel_ff <= 1'b0;
      rs_ok_ff <= 1'b0;
      wend_ff <= 1'b0;
      go_st_ff <= 1'b0;
      go_sp_ff <= 1'b0;
      fast_ff <= 1'b0;
      sp_sent_ff <= 1'b0;
      ack_ff <= 1'b0;
      irq_st_ff <= '0;
      irq_mask_ff <= sstc_pkg::IRQ_MASK_RST;
      rdata_ff <= sstc_pkg::RDATA_RST;
    end else begin
      ue_ff <= nxt_ue;
      acke_ff <= nxt_acke;
      wtim_ff <= nxt_wtim;
      stt_ff <= nxt_stt;
      spt_ff <= nxt_spt;
      rsvd_ff <= nxt_rsvd;
      stcf_ff <= nxt_stcf;
      msts_ff <= nxt_msts;
      ald_ff <= nxt_ald;
      trc_ff <= nxt_trc;
      sda_rel_ff <= nxt_sda_rel;
      rs_ok_ff <= nxt_rs_ok;
      wend_ff <= nxt_wend;
      go_st_ff <= nxt_go_st;
      go_sp_ff <= nxt_go_sp;
      fast_ff <= nxt_fast;
      sp_sent_ff <= nxt_sp_sent;
      ack_ff <= nxt_ack;
      irq_st_ff <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // trigger bits never read back
  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = req & ~ack_ff;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = gen_scl_oe | eng_scl_oe_i;
  // data line released after transmit wait release
  assign sda_oe_o = gen_sda_oe | (eng_sda_oe_i & ~sda_rel_ff);
  assign unit_enable_o = ue_ff;
  assign ack_enable_o = acke_ff;
  assign wait_timing_o = wtim_ff;
  assign wait_end_o = wend_ff;
  assign irq_o = |(irq_st_ff & irq_mask_ff);
endmodule : sstc_trigger_ctrl

// ==== shared/sstc_pkg.sv ====
// Constants and types shared by the start/stop trigger control block
package sstc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int START_SU_NS = 4700;
  localparam int START_HD_NS = 4000;
  localparam int START_SU_CYC = (START_SU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HD_CYC = (START_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C0_UNIT_ENABLE = 7;
  localparam int C0_EXIT_COMM = 6;
  localparam int C0_WAIT_RELEASE = 5;
  localparam int C0_ACK_ENABLE = 4;
  localparam int C0_WAIT_TIMING = 3;
  localparam int C0_START_TRIG = 1;
  localparam int C0_STOP_TRIG = 0;
  localparam int FL_START_CLEAR = 7;
  localparam int FL_BUS_BUSY = 6;
  localparam int FL_RSV_DISABLE = 0;
  localparam int ST_MASTER = 7;
  localparam int ST_ARB_LOST = 6;
  localparam int ST_TRANSMIT = 3;
  localparam int IRQ_W = 4;
  localparam int IRQ_START_DONE = 0;
  localparam int IRQ_STOP_SEEN = 1;
  localparam int IRQ_ARB_LOST = 2;
  localparam int IRQ_START_CLR = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Condition generator states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GEN_IDLE,
    GEN_ST_SU,
    GEN_ST_HD,
    GEN_ST_LOW,
    GEN_SP_LOW,
    GEN_SP_SU
  } sstc_gen_state_type;
endpackage : sstc_pkg

// ==== tb/sstc_bus_model.sv ====
// Partner model: pulled-up bus lines and a second bus master
module sstc_bus_model (
  input wire logic clk_i,    // System clock
  input wire logic scl_oe_i, // Design pulls clock low
  input wire logic sda_oe_i, // Design pulls data low
  output logic scl_o,        // Clock line level
  output logic sda_o         // Data line level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_scl_ff = 1'b0;
  logic ext_sda_ff = 1'b0;
  // Pull-ups: a released line reads high
  assign scl_o = ~(scl_oe_i | ext_scl_ff);
  assign sda_o = ~(sda_oe_i | ext_sda_ff);
  // Data falls while clock high, then clock is held low
  task ext_start;
    @(posedge clk_i);
    ext_sda_ff <= 1'b1;
    repeat (10) @(posedge clk_i);
    ext_scl_ff <= 1'b1;
  endtask : ext_start
  // Clock released first, then data rises
  task ext_stop;
    @(posedge clk_i);
    ext_scl_ff <= 1'b0;
    repeat (10) @(posedge clk_i);
    ext_sda_ff <= 1'b0;
  endtask : ext_stop
endmodule : sstc_bus_model

// ==== tb/sstc_trigger_ctrl_assertions.sv ====
// Port checks of the start/stop trigger control block
module sstc_trigger_ctrl_chk (
  input wire logic clk_i,                  // System clock
  input wire logic sys_rst_i,              // Async reset
  input wire logic [4:0] avs_address_i,    // Address
  input wire logic avs_read_i,             // Read
  input wire logic avs_write_i,            // Write
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  input wire logic [31:0] avs_readdata_o,  // Read data
  input wire logic avs_waitrequest_o,      // Stall
  input wire logic scl_oe_o,               // Clock pulled low
  input wire logic sda_oe_o,               // Data pulled low
  input wire logic eng_scl_oe_i,           // Engine clock pull
  input wire logic eng_sda_oe_i,           // Engine data pull
  input wire logic mst_wait_i,             // Master wait
  input wire logic wait8_i,                // Wait after eight
  input wire logic shift_wr_i,             // Shift write
  input wire logic unit_enable_o,          // Unit enable
  input wire logic ack_enable_o,           // Ack enable
  input wire logic wait_timing_o,          // Wait timing
  input wire logic wait_end_o              // Wait released
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr0;
  logic rd0;
  logic [10:0] dis_cnt_ff;
  logic [10:0] nxt_dis_cnt;
  assign wr0 = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
    && avs_address_i == sstc_pkg::ADDR_CTRL0;
  assign rd0 = avs_read_i && !avs_waitrequest_o && avs_address_i == sstc_pkg::ADDR_CTRL0;
  // Cycles spent with the unit disabled, saturating
  always_comb begin
    nxt_dis_cnt = dis_cnt_ff;
    if (unit_enable_o) begin
      nxt_dis_cnt = 11'h000;
    end else if (dis_cnt_ff != 11'h7FF) begin
      nxt_dis_cnt = dis_cnt_ff + 11'h001;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dis_cnt_ff <= 11'h000;
    end else begin
      dis_cnt_ff <= nxt_dis_cnt;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  chk_trig_read_zero: assert property (rd0 |-> avs_readdata_o[1:0] == 2'h0)
    else $error("trigger bits read back nonzero");
  chk_unit_level: assert property (wr0 |=> unit_enable_o == $past(avs_writedata_i[7]))
    else $error("unit enable level wrong");
  chk_ack_level: assert property (wr0 |=> ack_enable_o == $past(avs_writedata_i[4]))
    else $error("ack enable level wrong");
  chk_timing_level: assert property (wr0 |=> wait_timing_o == $past(avs_writedata_i[3]))
    else $error("wait timing level wrong");
  chk_release_pulse: assert property (wr0 && avs_writedata_i[5] && mst_wait_i
    && unit_enable_o |=> wait_end_o) else $error("wait release gave no pulse");
  chk_shift_release: assert property (shift_wr_i && mst_wait_i && unit_enable_o
    |=> wait_end_o) else $error("shift write gave no release");
  chk_disabled_quiet: assert property (dis_cnt_ff >= 11'h5DC && !eng_sda_oe_i
    && !eng_scl_oe_i |-> !sda_oe_o && !scl_oe_o) else $error("lines pulled while disabled");
  chk_start_hold: assert property ($rose(sda_oe_o) && !scl_oe_o && !eng_sda_oe_i
    && !wait8_i && !mst_wait_i |-> !scl_oe_o [*8] ##[1:600] scl_oe_o)
    else $error("start condition shape wrong");
  cover property (rd0);
  cover property (wait_end_o);
  cover property ($rose(sda_oe_o) && !scl_oe_o);
endmodule : sstc_trigger_ctrl_chk
bind sstc_trigger_ctrl sstc_trigger_ctrl_chk i_sstc_trigger_ctrl_chk (
  .clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .scl_oe_o, .sda_oe_o,
  .eng_scl_oe_i, .eng_sda_oe_i, .mst_wait_i, .wait8_i, .shift_wr_i, .unit_enable_o,
  .ack_enable_o, .wait_timing_o, .wait_end_o
);

// ==== tb/sstc_trigger_ctrl_tb_top.sv ====
// Self-checking testbench of the start/stop trigger control block
module sstc_trigger_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] C0 = sstc_pkg::ADDR_CTRL0;
  localparam logic [4:0] FL = sstc_pkg::ADDR_FLAG;
  localparam logic [4:0] ST = sstc_pkg::ADDR_STAT;
  localparam logic [4:0] IS = sstc_pkg::ADDR_IRQ_STAT;
  localparam logic [4:0] IM = sstc_pkg::ADDR_IRQ_MASK;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, scl, sda, scl_oe, sda_oe, uen, ack, wtim, wend, irq;
  logic eng_sda = 1'b0;
  logic eng_scl = 1'b0;
  logic mwait = 1'b0;
  logic w8 = 1'b0;
  logic ninth = 1'b0;
  logic nhigh = 1'b0;
  logic txs = 1'b0;
  logic shw = 1'b0;
  logic arb = 1'b0;
  logic [7:0] d;
  int n_fail = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  sstc_trigger_ctrl i_sstc_trigger_ctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd_q),
    .avs_write_i(wr_q), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .eng_scl_oe_i(eng_scl),
    .eng_sda_oe_i(eng_sda), .mst_wait_i(mwait), .wait8_i(w8), .ninth_clk_i(ninth),
    .ninth_high_i(nhigh), .tx_set_i(txs), .shift_wr_i(shw), .arb_lost_i(arb),
    .unit_enable_o(uen), .ack_enable_o(ack), .wait_timing_o(wtim), .wait_end_o(wend),
    .irq_o(irq)
  );
  sstc_bus_model i_sstc_bus_model (
    .clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda)
  );
  // ----------------------------------------------------------------
  // Bus access and compare tasks
  // ----------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_i);
    adr <= a;
    wdat <= {24'h0, v};
    wr_q <= 1'b1;
    do @(posedge clk_i); while (wreq !== 1'b0);
    wr_q <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a);
    @(posedge clk_i);
    adr <= a;
    rd_q <= 1'b1;
    do @(posedge clk_i); while (wreq !== 1'b0);
    d = rdat[7:0];
    rd_q <= 1'b0;
  endtask : rd
  task cmp(input logic [7:0] e);
    checks++;
    if (d !== e) begin
      n_fail++;
      $display("MISMATCH %0t register got %h expected %h", $time, d, e);
    end
  endtask : cmp
  task cmpb(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t line got %b expected %b", $time, g, e);
    end
  endtask : cmpb
  task rc(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    cmp(e);
  endtask : rc
  task poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 2000; i++) begin
      rd(a);
      if ((d & m) === e) break;
    end
    d = d & m;
    cmp(e);
  endtask : poll
  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    sys_rst_i <= 1'b0;
    rc(C0, 8'h00);
    rc(FL, 8'h00);
    rc(ST, 8'h00);
    rc(IM, 8'h00);
    wr(5'h14, 8'hFF);
    rc(5'h14, 8'h00);
    $display("test reset values done");
    wr(C0, 8'h02);
    tick(1500);
    rc(ST, 8'h00);
    cmpb(sda, 1'b1);
    $display("test disabled unit done");
    wr(C0, 8'h80);
    wr(C0, 8'h82);
    rc(C0, 8'h80);
    poll(ST, 8'h80, 8'h80);
    rc(IS, 8'h01);
    cmpb(irq, 1'b0);
    wr(IM, 8'h0F);
    tick(2);
    cmpb(irq, 1'b1);
    wr(IS, 8'h0F);
    tick(2);
    cmpb(irq, 1'b0);
    $display("test start and interrupt done");
    mwait <= 1'b1;
    wr(C0, 8'h81);
    poll(FL, 8'h40, 8'h00);
    rc(IS, 8'h02);
    mwait <= 1'b0;
    wr(IS, 8'h0F);
    $display("test stop done");
    i_sstc_bus_model.ext_start();
    wr(FL, 8'h01);
    wr(C0, 8'h82);
    rc(FL, 8'hC1);
    rc(IS, 8'h08);
    rc(ST, 8'h00);
    wr(FL, 8'h80);
    rc(FL, 8'h40);
    wr(C0, 8'h82);
    tick(100);
    rc(ST, 8'h00);
    i_sstc_bus_model.ext_stop();
    poll(ST, 8'h80, 8'h80);
    $display("test busy bus done");
    wr(IS, 8'h0F);
    w8 <= 1'b1;
    mwait <= 1'b1;
    wr(C0, 8'h81);
    tick(50);
    rc(FL, 8'h40);
    nhigh <= 1'b1;
    poll(FL, 8'h40, 8'h00);
    nhigh <= 1'b0;
    w8 <= 1'b0;
    mwait <= 1'b0;
    $display("test ninth clock stop done");
    wr(C0, 8'h82);
    poll(ST, 8'h80, 8'h80);
    txs <= 1'b1;
    tick(1);
    txs <= 1'b0;
    rc(ST, 8'h88);
    mwait <= 1'b1;
    ninth <= 1'b1;
    eng_sda <= 1'b1;
    eng_scl <= 1'b1;
    wr(IS, 8'h0F);
    wr(C0, 8'h82);
    wr(C0, 8'hA0);
    rc(ST, 8'h80);
    cmpb(sda_oe, 1'b0);
    mwait <= 1'b0;
    ninth <= 1'b0;
    eng_sda <= 1'b0;
    eng_scl <= 1'b0;
    poll(IS, 8'h01, 8'h01);
    $display("test release and restart done");
    mwait <= 1'b1;
    shw <= 1'b1;
    tick(1);
    shw <= 1'b0;
    mwait <= 1'b0;
    wr(C0, 8'h81);
    arb <= 1'b1;
    tick(1);
    arb <= 1'b0;
    rc(ST, 8'h40);
    rc(IS, 8'h05);
    rc(ST, 8'h00);
    mwait <= 1'b1;
    tick(1000);
    rc(FL, 8'h40);
    mwait <= 1'b0;
    wr(C0, 8'h82);
    wr(C0, 8'hC0);
    i_sstc_bus_model.ext_start();
    i_sstc_bus_model.ext_stop();
    tick(600);
    rc(FL, 8'h00);
    wr(C0, 8'h00);
    tick(1600);
    $display("test arbitration loss done");
    results();
  end
  initial begin
    tick(40000);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end
endmodule : sstc_trigger_ctrl_tb_top
